// ==== src/spg_top.sv ====
// Host serial port, pulse link master and host-clocked GPIO bus master
//
// Functional notes
// - Every GPIO master edge is taken from a host serial clock edge or host select rise, never from a timer.
// - In I2C mode the master clock is low one host period and high one host period within a byte; between bytes it is held low.
// - The first master clock fall comes one host low phase after master select falls.
// - Master data is held from a master clock rise for one host period plus a high phase.
// - In pulse mode the internal clock high phase is made inside, at least 30 ns long.
// - The mode strap tied low selects the four-wire slave, otherwise the pulse link.
// - The four-wire port is mode 1,1 and samples host data on each rising clock edge.
// - The host serial output only pulls low; an external pull-up gives the high level.
// - The chained variant always runs its second port as pulse-link master.
// - The addressable variant reads its address from four straps and has no second port.
// - On the pulse link, select, clock and data events travel as differential pulses.
// - Select rise and fall go out as long pulses, clock rises as short data-signed pulses.
`timescale 1ns/1ps
module spg_top #(
  parameter bit DAISY_CHAIN = 1'b1
) (
  input  wire logic                      clk_in,
  input  wire logic                      reset_in,
  input  wire logic                      port_a_mode_strap_in,
  input  wire logic [3:0]                addr_strap_in,
  input  wire logic                      host_chip_select_n_in,
  input  wire logic                      host_serial_clock_in,
  input  wire logic                      host_serial_in_in,
  output logic                           host_serial_out_out,
  output logic                           host_serial_out_oe_out,
  input  wire logic                      port_a_pos_in,
  input  wire logic                      port_a_neg_in,
  output logic                           port_b_pos_out,
  output logic                           port_b_neg_out,
  input  wire logic                      start_gpio_transfer_cmd_in,
  input  wire logic                      i2c_select_in,
  input  wire logic [spg_pkg::BYTE_W-1:0] tx_byte_in,
  input  wire logic                      tx_valid_in,
  output logic                           tx_ready_out,
  output logic [spg_pkg::BYTE_W-1:0]     rx_byte_out,
  output logic                           rx_valid_out,
  output logic                           master_chip_select_n_out,
  output logic                           master_serial_clock_out,
  input  wire logic                      master_data_io_in,
  output logic                           master_data_io_out,
  output logic                           master_data_io_oe_out,
  output logic                           pulse_mode_out,
  output logic [3:0]                     device_address_out
);
  import spg_pkg::*;

  spg_state_t q;
  spg_state_t d;
  spg_fifo_if #(.W(BYTE_W)) fif ();

  spg_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .f        (fif.fifo)
  );

  assign fif.wdata  = tx_byte_in;
  assign fif.wvalid = tx_valid_in;

  logic cs_i;
  logic sck_i;
  logic sdi_i;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic load;

  always_comb begin
    d = q;
    load = 1'b0;
    d.meta = {addr_strap_in, master_data_io_in,
              port_a_neg_in, port_a_pos_in, port_a_mode_strap_in, host_serial_in_in,
              host_chip_select_n_in, host_serial_clock_in};
    d.syn = q.meta;
    // Straps are caught once the synchroniser has filled after reset
    if (!q.strap_done) begin
      d.strap_cnt = q.strap_cnt + 2'h1;
      if (q.strap_cnt == STRAP_WAIT) begin
        d.strap_done = 1'b1;
        d.pulse_mode = q.syn[SY_STRAP];
        d.addr       = DAISY_CHAIN ? 4'h0 : q.syn[SY_ADDR+3:SY_ADDR];
      end
    end
    // Pulse receiver: length of the first level tells long from short.
    // Short halves are near one clock, so a very narrow pulse can be missed.
    if (q.rx_wait) begin
      d.rx_wait = q.syn[SY_APOS] || q.syn[SY_ANEG];
    end else if (!q.rx_busy) begin
      if (q.syn[SY_APOS] || q.syn[SY_ANEG]) begin
        d.rx_busy = 1'b1;
        d.rx_pol  = q.syn[SY_APOS];
        d.rx_cnt  = 3'h1;
      end
    end else if ((q.rx_pol ? q.syn[SY_APOS] : q.syn[SY_ANEG]) && q.rx_cnt != 3'h7) begin
      d.rx_cnt = q.rx_cnt + 3'h1;
    end else begin
      d.rx_busy = 1'b0;
      d.rx_wait = 1'b1;
      if (q.rx_cnt >= 3'(LONG_HALF_CYC)) begin
        d.iso_cs = q.rx_pol;
      end else begin
        d.iso_sdi = q.rx_pol;
        d.iso_sck = 1'b1;
        d.iso_hi  = 2'(ISO_HIGH_CYC);
      end
    end
    if (q.iso_sck && q.iso_hi == 2'h1) begin
      d.iso_sck = 1'b0;
    end
    if (q.iso_hi != 2'h0) begin
      d.iso_hi = q.iso_hi - 2'h1;
    end
    cs_i  = q.pulse_mode ? q.iso_cs  : q.syn[SY_CSB];
    sck_i = q.pulse_mode ? q.iso_sck : q.syn[SY_SCK];
    sdi_i = q.pulse_mode ? q.iso_sdi : q.syn[SY_SDI];
    d.cs_p  = cs_i;
    d.sck_p = sck_i;
    rise    = sck_i && !q.sck_p && !cs_i;
    fall    = !sck_i && q.sck_p && !cs_i;
    cs_fall = !cs_i && q.cs_p;
    cs_rise = cs_i && !q.cs_p;
    // Four-wire slave return path: last master byte, shifted on falling edges
    // MSB stands from select fall through the first rise, so the first fall only arms
    if (cs_fall) begin
      d.sdo_sh   = q.last_rx;
      d.sdo_hold = 1'b1;
    end else if (fall) begin
      d.sdo_hold = 1'b0;
      if (!q.sdo_hold) begin
        d.sdo_sh = {q.sdo_sh[6:0], 1'b1};
      end
    end
    d.sdo_oe = !q.pulse_mode && !cs_i && !d.sdo_sh[7];
    // Pulse link master toward the next device; an event that lands while a
    // pulse is still going out is dropped, which host timing rules out
    if (q.pb_left != 3'h0) begin
      d.pb_left = q.pb_left - 3'h1;
    end else if (DAISY_CHAIN && (cs_fall || cs_rise || rise)) begin
      d.pb_half = (cs_fall || cs_rise) ? 3'(LONG_HALF_CYC) : 3'(SHORT_HALF_CYC);
      d.pb_left = {d.pb_half[1:0], 1'b0};
      d.pb_sign = (cs_fall || cs_rise) ? cs_rise : sdi_i;
    end
    d.pb_pos = (d.pb_left != 3'h0) && ((d.pb_left > d.pb_half) == d.pb_sign);
    d.pb_neg = (d.pb_left != 3'h0) && ((d.pb_left > d.pb_half) != d.pb_sign);
    // GPIO master, started by the start command, stepped by host clock edges, ended early by host select rise
    d.rx_vld = 1'b0;
    case (q.st)
      SPG_IDLE: begin
        if (start_gpio_transfer_cmd_in) begin
          d.st    = SPG_RUN;
          d.rc    = BYTE_HOST_CLKS;
          d.first = 1'b1;
          d.i2c   = i2c_select_in;
        end
      end
      SPG_RUN: begin
        if (cs_rise) begin
          d.st    = SPG_IDLE;
          d.m_cs  = 1'b1;
          d.m_sck = 1'b1;
          d.m_oe  = 1'b0;
        end else if (fall && q.rc == BYTE_HOST_CLKS) begin
          if (fif.rvalid && !(q.last && !q.first)) begin
            load    = 1'b1;
            d.rc    = 5'h0;
            d.last  = 1'b0;
            // SPI puts the MSB out at load; I2C sends it at the first fall
            d.tx_sh = q.i2c ? fif.rdata : {fif.rdata[6:0], 1'b1};
            if (q.i2c) begin
              if (q.first) begin
                d.m_do = 1'b0;
                d.m_oe = 1'b1;
              end
            end else begin
              d.m_cs = 1'b0;
              d.m_do = fif.rdata[7];
              d.m_oe = 1'b1;
            end
            d.first = 1'b0;
          end else if (q.last) begin
            d.st = SPG_IDLE;
          end
        end else if (rise && q.rc < BYTE_HOST_CLKS) begin
          d.rc = q.rc + 5'h1;
          if (q.rc < LAST_RISE) begin
            d.m_sck = q.rc[0] || (!q.i2c && q.rc >= SPI_BIT_RISES);
          end
          if (q.rc[0] && q.rc < SPI_BIT_RISES) begin
            d.rx_sh = {q.rx_sh[6:0], q.syn[SY_MDIN]};
          end
          if (q.rc == LAST_RISE) begin
            d.last = !fif.rvalid;
            d.m_cs = !fif.rvalid || q.i2c;
            if (q.i2c) begin
              d.m_sck = 1'b0;
            end
          end
          if (q.i2c && q.rc == STOP_RISE) begin
            d.m_sck = q.last;
          end
          if (q.rc == BYTE_HOST_CLKS - 5'h1) begin
            d.rx_byte = q.rx_sh;
            d.last_rx = q.rx_sh;
            d.rx_vld  = 1'b1;
          end
        end else if (fall && q.rc[0] && q.rc <= ACK_FALL && (q.i2c || q.rc > 5'h1)) begin
          d.m_do  = q.tx_sh[7];
          d.m_oe  = !q.i2c || !q.tx_sh[7];
          d.tx_sh = {q.tx_sh[6:0], 1'b1};
        end else if (fall && q.i2c && q.last) begin
          if (q.rc == STOP_RISE) begin
            d.m_do = 1'b0;
            d.m_oe = 1'b1;
          end else if (q.rc == STOP_FALL) begin
            d.m_oe = 1'b0;
          end
        end
        if (!q.i2c && q.rc >= LAST_RISE && q.last && d.m_cs) begin
          d.m_oe = 1'b0;
        end
      end
      default: begin
        d.st = SPG_IDLE;
      end
    endcase
    if (q.i2c) begin
      d.m_do = 1'b0;                                                       // Open drain: only pulls low
    end
    fif.rready = load;
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q        <= '0;
      q.st     <= SPG_IDLE;
      q.cs_p   <= 1'b1;
      // Synchroniser and edge history start at the idle pin levels: no false edge
      q.sck_p  <= 1'b1;
      q.meta[SY_CSB] <= 1'b1;
      q.meta[SY_SCK] <= 1'b1;
      q.syn[SY_CSB]  <= 1'b1;
      q.syn[SY_SCK]  <= 1'b1;
      q.iso_cs <= 1'b1;
      q.m_cs   <= 1'b1;
      q.m_sck  <= 1'b1;
      q.sdo_sh <= 8'hFF;
    end else begin
      q <= d;
    end
  end

  assign host_serial_out_out      = 1'b0;
  assign host_serial_out_oe_out   = q.sdo_oe;
  assign port_b_pos_out           = q.pb_pos;
  assign port_b_neg_out           = q.pb_neg;
  assign tx_ready_out             = fif.wready;
  assign rx_byte_out              = q.rx_byte;
  assign rx_valid_out             = q.rx_vld;
  assign master_chip_select_n_out = q.m_cs;
  assign master_serial_clock_out  = q.m_sck;
  assign master_data_io_out       = q.m_do;
  assign master_data_io_oe_out    = q.m_oe;
  assign pulse_mode_out           = q.pulse_mode;
  assign device_address_out       = q.addr;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (reset_in);

  host_edge_a: assert property ($changed(q.m_sck) |-> $past(rise))
    else $error("master clock moved without a host rising edge");
  i2c_high_a: assert property (q.i2c && $rose(q.m_sck) |=> q.m_sck [*4])
    else $error("I2C clock high phase too short");
  cs_lead_a: assert property ($fell(q.m_cs) |-> q.m_sck ##1 q.m_sck)
    else $error("master clock fell together with master select");
  spi_hold_a: assert property (!q.i2c && $rose(q.m_sck) |=> $stable(q.m_do) [*4])
    else $error("master data changed too soon after clock rise");
  iso_high_a: assert property ($rose(q.iso_sck) |=> !q.iso_sck)
    else $error("internal high phase length wrong");
  mode_hold_a: assert property (q.strap_done |=> $stable(q.pulse_mode) && $stable(q.addr))
    else $error("strap value changed after capture");
  sdo_pull_a: assert property (q.sdo_oe |-> !host_serial_out_out && !q.pulse_mode)
    else $error("host output driven high or in pulse mode");
  port_b_a: assert property (!DAISY_CHAIN |-> !q.pb_pos && !q.pb_neg)
    else $error("second port active in addressable variant");
  pulse_pair_a: assert property (!(q.pb_pos && q.pb_neg))
    else $error("both pulse drivers on");
  long_neg_a: assert property (cs_fall && q.pb_left == 3'h0 && DAISY_CHAIN
                               |=> q.pb_neg [*2] ##1 q.pb_pos [*2])
    else $error("select fall not sent as long negative pulse");
  cs_gap_a: assert property ($rose(q.m_cs) |=> q.m_cs [*8])
    else $error("master select high time too short");
  spi_run_c: cover property (!q.i2c && q.rx_vld);
  i2c_run_c: cover property (q.i2c && q.rx_vld && q.last);
  long_tx_c: cover property ($rose(q.pb_pos) && q.pb_half == 3'(LONG_HALF_CYC));
  pulse_rx_c: cover property (q.pulse_mode && $rose(q.iso_sck));
endmodule

// ==== src/spg_pkg.sv ====
// Constants and state types for the serial port and GPIO master block
package spg_pkg;
  localparam int CLK_PERIOD_NS    = 100;
  localparam int ISO_HIGH_MIN_NS  = 30;
  localparam int ISO_HIGH_RAW     = (ISO_HIGH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ISO_HIGH_CYC     = (ISO_HIGH_RAW < 1) ? 1 : ISO_HIGH_RAW;
  localparam int LONG_HALF_NS     = 150;
  localparam int LONG_HALF_RAW    = (LONG_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_HALF_CYC    = (LONG_HALF_RAW < 1) ? 1 : LONG_HALF_RAW;
  localparam int SHORT_HALF_NS    = 50;
  localparam int SHORT_HALF_RAW   = (SHORT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_HALF_CYC   = (SHORT_HALF_RAW < 1) ? 1 : SHORT_HALF_RAW;
  localparam logic [4:0] BYTE_HOST_CLKS = 5'h18;
  localparam logic [4:0] SPI_BIT_RISES  = 5'h10;
  localparam logic [4:0] LAST_RISE      = 5'h12;
  localparam logic [4:0] STOP_RISE      = 5'h13;
  localparam logic [4:0] STOP_FALL      = 5'h14;
  localparam logic [4:0] ACK_FALL       = 5'h11;
  localparam logic [1:0] STRAP_WAIT     = 2'h2;
  localparam int BYTE_W     = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_W     = 11;
  localparam int SY_SCK = 0;
  localparam int SY_CSB = 1;
  localparam int SY_SDI = 2;
  localparam int SY_STRAP = 3;
  localparam int SY_APOS = 4;
  localparam int SY_ANEG = 5;
  localparam int SY_MDIN = 6;
  localparam int SY_ADDR = 7;

  typedef enum logic [1:0] {
    SPG_IDLE = 2'b01,
    SPG_RUN  = 2'b10
  } spg_mst_t;

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] syn;
    logic [1:0]        strap_cnt;
    logic              strap_done;
    logic              pulse_mode;
    logic [3:0]        addr;
    logic              cs_p;
    logic              sck_p;
    logic              rx_busy;
    logic              rx_wait;
    logic              rx_pol;
    logic [2:0]        rx_cnt;
    logic              iso_cs;
    logic              iso_sdi;
    logic              iso_sck;
    logic [1:0]        iso_hi;
    logic [7:0]        sdo_sh;
    logic              sdo_oe;
    logic              sdo_hold;
    logic [7:0]        last_rx;
    spg_mst_t          st;
    logic [4:0]        rc;
    logic              first;
    logic              last;
    logic              i2c;
    logic [7:0]        tx_sh;
    logic [7:0]        rx_sh;
    logic              m_cs;
    logic              m_sck;
    logic              m_do;
    logic              m_oe;
    logic [7:0]        rx_byte;
    logic              rx_vld;
    logic [2:0]        pb_left;
    logic [2:0]        pb_half;
    logic              pb_sign;
    logic              pb_pos;
    logic              pb_neg;
  } spg_state_t;
endpackage

// ==== src/spg_fifo_if.sv ====
// Byte stream carrier between the block and its FIFO
`timescale 1ns/1ps
interface spg_fifo_if #(parameter int W = 8);
  logic [W-1:0] wdata;
  logic         wvalid;
  logic         wready;
  logic [W-1:0] rdata;
  logic         rvalid;
  logic         rready;
  modport fifo (input wdata, input wvalid, output wready,
                output rdata, output rvalid, input rready);
  modport user (output wdata, output wvalid, input wready,
                input rdata, input rvalid, output rready);
endinterface

// ==== src/spg_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ps
module spg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic clk_in,
  input  wire logic reset_in,
  spg_fifo_if.fifo  f
);
  import spg_pkg::*;
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
    logic          wready;
  } spg_fifo_state_t;

  spg_fifo_state_t        q;
  spg_fifo_state_t        d;
  logic [WIDTH-1:0]       mem [DEPTH];
  logic                   push;
  logic                   pop;

  // Ready is registered so the writer never sees a combinational path
  assign push      = f.wvalid && q.wready;
  assign pop       = f.rready && (q.cnt != '0);
  assign f.wready  = q.wready;
  assign f.rvalid  = (q.cnt != '0);
  assign f.rdata   = mem[q.rp];

  always_comb begin
    d = q;
    if (push) begin
      d.wp = q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt    = q.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    d.wready = (d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q        <= '0;
      q.wready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[q.wp] <= f.wdata;
    end
  end
endmodule

// ==== tb/spg_slave_model.sv ====
// Partner model: SPI slave hanging on the GPIO master port
`timescale 1ns/1ps
module spg_slave_model #(
  parameter logic [7:0] REPLY = 8'h3C
) (
  input  wire logic select_n_in,
  input  wire logic sclk_in,
  output logic      data_out
);
  logic [7:0] sh_q;
  initial begin
    sh_q = REPLY;
    data_out = 1'h0;
  end
  always @(negedge select_n_in) begin
    sh_q = REPLY;
  end
  // Answers 300 ns into the low phase, well inside one host period
  always @(negedge sclk_in) begin
    if (select_n_in === 1'h0) begin
      #300;
      data_out = sh_q[7];
      sh_q = {sh_q[6:0], sh_q[7]};
    end
  end
  // Deselected: show the inverse, so a stale bit never passes for data
  always @(posedge select_n_in) begin
    data_out = ~data_out;
  end
endmodule

// ==== tb/spg_top_tb.sv ====
// Self-checking bench for the host port, pulse link and GPIO master
`timescale 1ns/1ps
module spg_top_tb;
  import spg_pkg::*;
  localparam realtime LOW_NS  = 500.0;
  localparam realtime PER_NS  = 800.0;
  localparam realtime HOLD_NS = 1100.0;
  logic       clk_in = 1'h0, reset_in = 1'h1, strap1 = 1'h0, strap2 = 1'h1;
  logic       hcs_n = 1'h1, hsck = 1'h1, hsdi = 1'h0, apos = 1'h0, aneg = 1'h0;
  logic       st1 = 1'h0, st2 = 1'h0, i2c_sel = 1'h0, v1 = 1'h0, v2 = 1'h0;
  logic       mon_on = 1'h0, armed = 1'h0, in_p = 1'h0, seen = 1'h0, fpos;
  logic       host_serial_out, sdo_oe, sdo_oe2, bpos, bneg, bpos2, bneg2, rdy1, rxv1, rxv2;
  logic       mcs, msck, mdo, moe, mdo2, moe2, pm1, pm2, s_data, mdio1, mdio2;
  logic [3:0] addr_strap = 4'hA, da1, da2;
  logic [7:0] txb = 8'h00, rxb1, rxb2, last1, last2, got;
  logic [2:0] run;
  logic [1:0] evq[$];
  int         error_cnt = 0, check_count = 0, rx_cnt1 = 0, rx_cnt2 = 0, rises = 0;
  realtime    t_cs = 0, t_fall = 0, t_rise = 0;

  // SDA has a pull-up; in SPI mode the slave answers when the master lets go
  assign mdio1 = (moe === 1'h1) ? mdo : (i2c_sel ? 1'h1 : s_data);
  assign mdio2 = (moe2 === 1'h1) ? mdo2 : 1'h1;

  spg_top #(.DAISY_CHAIN(1'h1)) dut (.clk_in(clk_in), .reset_in(reset_in),
    .port_a_mode_strap_in(strap1), .addr_strap_in(addr_strap), .host_chip_select_n_in(hcs_n),
    .host_serial_clock_in(hsck), .host_serial_in_in(hsdi), .host_serial_out_out(host_serial_out),
    .host_serial_out_oe_out(sdo_oe), .port_a_pos_in(apos), .port_a_neg_in(aneg),
    .port_b_pos_out(bpos), .port_b_neg_out(bneg), .start_gpio_transfer_cmd_in(st1),
    .i2c_select_in(i2c_sel), .tx_byte_in(txb), .tx_valid_in(v1), .tx_ready_out(rdy1),
    .rx_byte_out(rxb1), .rx_valid_out(rxv1), .master_chip_select_n_out(mcs),
    .master_serial_clock_out(msck), .master_data_io_in(mdio1), .master_data_io_out(mdo),
    .master_data_io_oe_out(moe), .pulse_mode_out(pm1), .device_address_out(da1));
  spg_top #(.DAISY_CHAIN(1'h0)) dut_addr (.clk_in(clk_in), .reset_in(reset_in),
    .port_a_mode_strap_in(strap2), .addr_strap_in(addr_strap), .host_chip_select_n_in(hcs_n),
    .host_serial_clock_in(hsck), .host_serial_in_in(hsdi), .host_serial_out_out(),
    .host_serial_out_oe_out(sdo_oe2), .port_a_pos_in(apos), .port_a_neg_in(aneg),
    .port_b_pos_out(bpos2), .port_b_neg_out(bneg2), .start_gpio_transfer_cmd_in(st2),
    .i2c_select_in(i2c_sel), .tx_byte_in(txb), .tx_valid_in(v2), .tx_ready_out(),
    .rx_byte_out(rxb2), .rx_valid_out(rxv2), .master_chip_select_n_out(),
    .master_serial_clock_out(), .master_data_io_in(mdio2), .master_data_io_out(mdo2),
    .master_data_io_oe_out(moe2), .pulse_mode_out(pm2), .device_address_out(da2));
  spg_slave_model #(.REPLY(8'h3C)) slave (.select_n_in(mcs), .sclk_in(msck), .data_out(s_data));

  initial begin
    forever #50 clk_in = ~clk_in;
  end

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'h1) begin
      $display("Error at %0t ns: %s", $time, msg);
      error_cnt++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  always @(posedge clk_in) begin
    if (rxv1 === 1'h1) begin
      rx_cnt1 <= rx_cnt1 + 1;
      last1 <= rxb1;
    end
    if (rxv2 === 1'h1) begin
      rx_cnt2 <= rx_cnt2 + 1;
      last2 <= rxb2;
    end
    if (reset_in === 1'h0) begin
      chk(!(bpos === 1'h1 && bneg === 1'h1), "port b drives both levels");
      chk(sdo_oe2 === 1'h0 && bpos2 === 1'h0 && bneg2 === 1'h0, "addressable unit drives");
    end
    // Port b decoder: first-level run of two clocks or more is a long pulse
    if (reset_in === 1'h0 && (bpos === 1'h1 || bneg === 1'h1)) begin
      if (!in_p) begin
        in_p <= 1'h1;
        fpos <= bpos;
        run <= 3'h1;
      end else if (!seen && bpos === fpos) begin
        run <= run + 3'h1;
      end else if (!seen) begin
        seen <= 1'h1;
        evq.push_back({run >= 3'h2, fpos});
      end
    end else begin
      in_p <= 1'h0;
      seen <= 1'h0;
    end
  end

  always @(negedge mcs) begin
    t_cs = $realtime;
    armed = 1'h1;
  end
  always @(negedge msck) begin
    if (armed && mcs === 1'h0) chk($realtime - t_cs == LOW_NS, "select to clock fall");
    armed = 1'h0;
    t_fall = $realtime;
  end
  always @(posedge msck) begin
    if (mon_on) begin
      chk($realtime - t_fall == PER_NS, "master clock low phase");
      rises++;
    end
    t_rise = $realtime;
  end
  always @(mdo) begin
    if (mon_on && moe === 1'h1 && mcs === 1'h0) chk($realtime - t_rise >= HOLD_NS, "data hold");
  end

  // Host bit: 500 ns low, 300 ns high; data held across the rise
  task automatic hbit(input logic b, output logic q);
    hsck <= 1'h0;
    hsdi <= b;
    cyc(4);
    #1 q = (sdo_oe === 1'h1) ? host_serial_out : 1'h1;
    cyc(1);
    hsck <= 1'h1;
    cyc(3);
  endtask

  task automatic frame(input int n, input logic [7:0] d);
    logic b;
    hcs_n <= 1'h0;
    cyc(4);
    for (int i = 0; i < n; i++) begin
      if (i == 100) cyc(40);
      hbit(d[7 - (i % 8)], b);
      got = {got[6:0], b};
    end
    cyc(2);
    hcs_n <= 1'h1;
    cyc(8);
  endtask

  task automatic pulse(input logic lng, input logic pos);
    apos <= pos;
    aneg <= ~pos;
    cyc(lng ? 2 : 1);
    apos <= ~pos;
    aneg <= pos;
    cyc(lng ? 2 : 1);
    apos <= 1'h0;
    aneg <= 1'h0;
    cyc(lng ? 4 : 6);
  endtask

  task automatic t_reset();
    chk(mcs === 1'h1 && msck === 1'h1 && moe === 1'h0, "master idle levels");
    chk(host_serial_out === 1'h0 && sdo_oe === 1'h0 && rdy1 === 1'h1, "host port idle");
    chk(pm1 === 1'h0 && da1 === 4'h0, "chained strap");
    chk(pm2 === 1'h1 && da2 === 4'hA, "addressable strap");
    $display("Test reset done");
  endtask

  task automatic t_fifo_spi();
    int n, r0, k0;
    n = 0;
    r0 = rx_cnt1;
    v1 <= 1'h1;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_in);
      if (rdy1 === 1'h1) begin
        n++;
        txb <= 8'(n);
      end
    end
    v1 <= 1'h0;
    cyc(1);
    chk(n == FIFO_DEPTH && rdy1 === 1'h0, "fifo refuses when full");
    k0 = rises;
    i2c_sel <= 1'h0;
    st1 <= 1'h1;
    cyc(1);
    st1 <= 1'h0;
    frame(384, 8'h00);
    chk(rx_cnt1 - r0 == 16 && rises - k0 == 128, "byte and clock counts");
    chk(rdy1 === 1'h1 && mcs === 1'h1, "fifo drained, select released");
    chk(last1 === 8'h0F, "spi last byte on shared data line");
    $display("Test fifo spi done");
  endtask

  task automatic t_i2c();
    int k0;
    k0 = rises;
    txb <= 8'hC3;
    v1 <= 1'h1;
    cyc(1);
    v1 <= 1'h0;
    i2c_sel <= 1'h1;
    st1 <= 1'h1;
    cyc(1);
    st1 <= 1'h0;
    frame(24, 8'h00);
    chk(last1 === 8'hC3 && rises - k0 == 10, "i2c byte and clocks");
    $display("Test i2c done");
  endtask

  task automatic t_host_frame();
    logic [1:0] e[10];
    evq.delete();
    frame(8, 8'h96);
    chk(got === 8'hC3, "host readback");
    chk(evq.size() == 10, "port b pulse count");
    e[0] = 2'h2;
    e[9] = 2'h3;
    for (int i = 1; i < 9; i++) e[i] = {1'h0, 1'(8'h96 >> (8 - i))};
    for (int i = 0; i < 10 && evq.size() == 10; i++) chk(evq[i] === e[i], "pulse kind");
    $display("Test host frame done");
  endtask

  task automatic t_pulse_link();
    int r0;
    r0 = rx_cnt2;
    txb <= 8'h5A;
    v2 <= 1'h1;
    cyc(1);
    v2 <= 1'h0;
    st2 <= 1'h1;
    cyc(1);
    st2 <= 1'h0;
    pulse(1'h1, 1'h0);
    for (int i = 0; i < 25; i++) pulse(1'h0, 1'h1);
    pulse(1'h1, 1'h1);
    cyc(8);
    chk(rx_cnt2 - r0 == 1 && last2 === 8'h5A, "pulse link byte");
    $display("Test pulse link done");
  endtask

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(6);
    reset_in <= 1'h0;
    cyc(4);
    mon_on = 1'h1;
    t_reset();
    t_fifo_spi();
    t_i2c();
    t_host_frame();
    t_pulse_link();
    wrap_up();
  end
endmodule
